// File: design/nvm_access_control.sv
// control register and trigger logic for software access to flash and data eeprom

// Functional notes
// RULE1: memory select one picks flash, zero eeprom
// RULE2: space select one picks configuration space
// RULE3: row erase armed: next write erases row
// RULE4: row erase clear: write only, no erase
// RULE5: reset during programming sets write abort flag
// RULE6: abort keeps memory select and row erase
// RULE7: writes start only with write permit set
// RULE8: write trigger starts cycle, cleared when done
// RULE9: software cannot clear the write trigger
// RULE10: read trigger reads one cycle, self clears
// RULE11: read trigger ignored while flash selected
// RULE12: defined bits reset zero, bit five reads zero
// RULE13: clear trigger and erase on array completion
module nvm_access_control (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_b,
	// warm resets that may cut a programming cycle
	input  wire logic        external_reset_pin_b,
	input  wire logic        watchdog_timer_reset,
	// register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// array side
	input  wire logic        nvm_prog_done,
	output logic             nvm_flash_sel,
	output logic             nvm_cfg_sel,
	output logic             nvm_read_req,
	output logic             nvm_prog_req,
	output logic             nvm_prog_erase,
	output logic             nvm_prog_abort,
	output logic             nvm_prog_busy
);

	// control bits
	logic       mem_sel_reg;
	logic       mem_sel_next;
	logic       cfg_sel_reg;
	logic       cfg_sel_next;
	logic       row_erase_reg;
	logic       row_erase_next;
	logic       abort_reg;
	logic       abort_next;
	logic       permit_reg;
	logic       permit_next;
	logic       wr_trig_reg;
	logic       wr_trig_next;
	logic       rd_trig_reg;
	logic       rd_trig_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// decode
	wire        warm_reset;
	wire        wr_hit;
	wire        rd_hit;
	wire        wr_start;
	wire        rd_start;
	wire        erase_in;
	wire        done_ev;
	wire        abort_ev;
	wire        seq_busy;
	wire [7:0]  ctrl_view;

	assign warm_reset = !external_reset_pin_b || watchdog_timer_reset;
	assign wr_hit     = reg_wr && (reg_addr == nvm_ctrl_pkg::NVM_CONTROL_OFS);
	assign rd_hit     = reg_rd && (reg_addr == nvm_ctrl_pkg::NVM_CONTROL_OFS);

	// a new cycle needs the permit already in place, so one stray write cannot program
	assign wr_start = wr_hit && reg_wdata[nvm_ctrl_pkg::WR_TRIG_BIT] && permit_reg  // RULE7
		&& !wr_trig_reg && !seq_busy && !warm_reset;                                   // RULE8

	assign rd_start = wr_hit && reg_wdata[nvm_ctrl_pkg::RD_TRIG_BIT]
		&& !reg_wdata[nvm_ctrl_pkg::MEM_SEL_BIT] && !warm_reset;                      // RULE11

	// erase choice as it stands after this write
	assign erase_in = wr_hit ? reg_wdata[nvm_ctrl_pkg::ROW_ERASE_BIT] : row_erase_reg; // RULE4

	assign done_ev  = seq_busy && nvm_prog_done && !warm_reset;                       // RULE13
	assign abort_ev = seq_busy && warm_reset;                                         // RULE5

	assign ctrl_view = {mem_sel_reg, cfg_sel_reg, 1'b0, row_erase_reg,               // RULE12
		abort_reg, permit_reg, wr_trig_reg, rd_trig_reg};

	// next values

	// selects survive a warm reset so a failed cycle can be traced
	assign mem_sel_next = wr_hit ? reg_wdata[nvm_ctrl_pkg::MEM_SEL_BIT] : mem_sel_reg; // RULE6
	assign cfg_sel_next = wr_hit ? reg_wdata[nvm_ctrl_pkg::CFG_SEL_BIT] : cfg_sel_reg;

	always_comb begin
		if (warm_reset) begin
			row_erase_next = seq_busy ? row_erase_reg : nvm_ctrl_pkg::ROW_ERASE_RST; // RULE6
		end else if (wr_hit) begin
			row_erase_next = reg_wdata[nvm_ctrl_pkg::ROW_ERASE_BIT];
		end else if (done_ev && nvm_prog_erase) begin
			row_erase_next = 1'b0;                                                 // RULE3
		end else begin
			row_erase_next = row_erase_reg;
		end
	end

	// the hardware set wins over any clear in the same cycle
	always_comb begin
		if (abort_ev) begin
			abort_next = 1'b1;                                                     // RULE5
		end else if (done_ev) begin
			abort_next = 1'b0;
		end else if (wr_hit) begin
			abort_next = reg_wdata[nvm_ctrl_pkg::ABORT_BIT];
		end else begin
			abort_next = abort_reg;
		end
	end

	assign permit_next = warm_reset ? nvm_ctrl_pkg::PERMIT_RST
		: (wr_hit ? reg_wdata[nvm_ctrl_pkg::PERMIT_BIT] : permit_reg);

	// a written zero never reaches the trigger: only start sets, only the array or a warm reset clears
	always_comb begin
		if (warm_reset) begin
			wr_trig_next = nvm_ctrl_pkg::WR_TRIG_RST;
		end else if (wr_start) begin
			wr_trig_next = 1'b1;                                                   // RULE8
		end else if (done_ev) begin
			wr_trig_next = 1'b0;                                                   // RULE13
		end else begin
			wr_trig_next = wr_trig_reg;                                            // RULE9
		end
	end

	// the read trigger lives for exactly one cycle
	assign rd_trig_next = rd_start;                                               // RULE10

	assign rdata_next = rd_hit ? ctrl_view : nvm_ctrl_pkg::UNMAPPED_RDATA;

	// state

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mem_sel_reg <= nvm_ctrl_pkg::MEM_SEL_RST;
			cfg_sel_reg <= nvm_ctrl_pkg::CFG_SEL_RST;
			abort_reg   <= nvm_ctrl_pkg::ABORT_RST;
		end else begin
			mem_sel_reg <= mem_sel_next;
			cfg_sel_reg <= cfg_sel_next;
			abort_reg   <= abort_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			row_erase_reg <= nvm_ctrl_pkg::ROW_ERASE_RST;                          // RULE12
			permit_reg    <= nvm_ctrl_pkg::PERMIT_RST;
			wr_trig_reg   <= nvm_ctrl_pkg::WR_TRIG_RST;
			rd_trig_reg   <= nvm_ctrl_pkg::RD_TRIG_RST;
		end else begin
			row_erase_reg <= row_erase_next;
			permit_reg    <= permit_next;
			wr_trig_reg   <= wr_trig_next;
			rd_trig_reg   <= rd_trig_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_reg <= nvm_ctrl_pkg::RDATA_RST;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// programming cycle sequencer

	nvm_prog_seq u_prog_seq (
		.mclk       (mclk),
		.rst_b      (rst_b),
		.start      (wr_start),
		.erase_in   (erase_in),
		.warm_reset (warm_reset),
		.prog_done  (nvm_prog_done),
		.prog_req   (nvm_prog_req),
		.prog_erase (nvm_prog_erase),
		.prog_abort (nvm_prog_abort),
		.busy       (seq_busy)
	);

	// outputs, all straight from flops
	assign reg_rdata     = rdata_reg;
	assign nvm_flash_sel = mem_sel_reg;                                           // RULE1
	assign nvm_cfg_sel   = cfg_sel_reg;                                           // RULE2
	assign nvm_read_req  = rd_trig_reg;                                           // RULE10
	assign nvm_prog_busy = seq_busy;

	// checks

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	a_flash_route: assert property ( // RULE1
		wr_hit |=> nvm_flash_sel == $past(reg_wdata[nvm_ctrl_pkg::MEM_SEL_BIT])
	) else $error("flash select does not follow write");

	a_space_route: assert property ( // RULE2
		wr_hit |=> nvm_cfg_sel == $past(reg_wdata[nvm_ctrl_pkg::CFG_SEL_BIT])
	) else $error("space select does not follow write");

	a_erase_clear_done: assert property ( // RULE3
		(done_ev && nvm_prog_erase && !wr_hit) |=> !row_erase_reg
	) else $error("row erase not cleared after erase");

	a_erase_follows_bit: assert property ( // RULE4
		wr_start |=> nvm_prog_req && (nvm_prog_erase == $past(erase_in))
	) else $error("program request erase mismatch");

	a_abort_flag_set: assert property ( // RULE5
		abort_ev |=> abort_reg && nvm_prog_abort && !nvm_prog_busy
	) else $error("abort not flagged after reset in cycle");

	a_abort_keeps_bits: assert property ( // RULE6
		abort_ev && !wr_hit |=> $stable(mem_sel_reg) && $stable(row_erase_reg)
	) else $error("select or erase bit lost on abort");

	a_start_needs_permit: assert property ( // RULE7
		$rose(wr_trig_reg) |-> $past(permit_reg) && nvm_prog_req
	) else $error("write started without permit");

	a_trigger_done_clear: assert property ( // RULE8
		done_ev |=> !wr_trig_reg ##1 !wr_trig_reg || $past(wr_start)
	) else $error("write trigger not cleared at completion");

	a_trigger_held: assert property ( // RULE9
		(wr_trig_reg && !done_ev && !warm_reset) |=> wr_trig_reg
	) else $error("write trigger cleared early");

	a_read_one_cycle: assert property ( // RULE10
		$rose(rd_trig_reg) |-> $past(rd_start) ##1 !rd_trig_reg
	) else $error("read trigger longer than one cycle");

	a_read_flash_block: assert property ( // RULE11
		(wr_hit && reg_wdata[nvm_ctrl_pkg::MEM_SEL_BIT]) |=> !nvm_read_req
	) else $error("read started with flash selected");

	a_unused_reads_zero: assert property ( // RULE12
		rd_hit |=> !reg_rdata[nvm_ctrl_pkg::UNUSED_BIT]
	) else $error("unimplemented bit reads one");

	a_trigger_fall_cause: assert property ( // RULE13
		$fell(wr_trig_reg) |-> $past(done_ev) || $past(warm_reset)
	) else $error("write trigger fell without completion");

	a_busy_drop_done: assert property ( // RULE13
		done_ev |=> !nvm_prog_busy && !wr_trig_reg
	) else $error("busy or trigger still set after completion");

	a_req_one_pulse: assert property ( // RULE8
		nvm_prog_req |-> nvm_prog_busy ##1 !nvm_prog_req
	) else $error("program request not a single pulse in a busy cycle");

	a_abort_one_pulse: assert property ( // RULE5
		nvm_prog_abort |=> !nvm_prog_abort
	) else $error("abort pulse longer than one cycle");

	a_abort_clear_done: assert property ( // RULE5
		done_ev |=> !abort_reg
	) else $error("abort flag set after normal completion");

	a_warm_stops_write: assert property ( // RULE7
		warm_reset |=> !permit_reg && !wr_trig_reg && !nvm_prog_busy
	) else $error("permit or cycle survives warm reset");

	a_permit_blocks_req: assert property ( // RULE7
		(wr_hit && !permit_reg) |=> !nvm_prog_req
	) else $error("program request without stored permit");

	a_zero_keeps_trigger: assert property ( // RULE9
		(wr_hit && !reg_wdata[nvm_ctrl_pkg::WR_TRIG_BIT] && wr_trig_reg && !done_ev
			&& !warm_reset) |=> wr_trig_reg
	) else $error("written zero cleared the write trigger");

	a_erase_off_write: assert property ( // RULE4
		(wr_start && !reg_wdata[nvm_ctrl_pkg::ROW_ERASE_BIT]) |=> !nvm_prog_erase
	) else $error("erase requested with row erase clear");

	a_erase_on_row: assert property ( // RULE3
		(wr_start && reg_wdata[nvm_ctrl_pkg::ROW_ERASE_BIT]) |=> nvm_prog_erase && row_erase_reg
	) else $error("row erase not requested when armed");

	a_read_starts: assert property ( // RULE10
		(wr_hit && reg_wdata[nvm_ctrl_pkg::RD_TRIG_BIT] && !reg_wdata[nvm_ctrl_pkg::MEM_SEL_BIT]
			&& !warm_reset) |=> nvm_read_req
	) else $error("read trigger did not start a read");

	a_select_kept_warm: assert property ( // RULE6
		(warm_reset && !wr_hit) |=> $stable(nvm_flash_sel) && $stable(nvm_cfg_sel)
	) else $error("select bits changed on warm reset");

	a_flash_sel_cause: assert property ( // RULE1
		$changed(nvm_flash_sel) |-> $past(wr_hit)
	) else $error("flash select changed without a write");

	a_cfg_sel_cause: assert property ( // RULE2
		$changed(nvm_cfg_sel) |-> $past(wr_hit)
	) else $error("space select changed without a write");

endmodule // nvm_access_control

// File: design/nvm_ctrl_pkg.sv
// constants and types shared by the nonvolatile access control block
package nvm_ctrl_pkg;

	// register map
	localparam logic [11:0] NVM_CONTROL_OFS = 12'hFA6;

	// field positions inside nvm_control
	localparam int MEM_SEL_BIT   = 7;
	localparam int CFG_SEL_BIT   = 6;
	localparam int UNUSED_BIT    = 5;
	localparam int ROW_ERASE_BIT = 4;
	localparam int ABORT_BIT     = 3;
	localparam int PERMIT_BIT    = 2;
	localparam int WR_TRIG_BIT   = 1;
	localparam int RD_TRIG_BIT   = 0;

	// reset values
	localparam logic MEM_SEL_RST   = 1'h0;
	localparam logic CFG_SEL_RST   = 1'h0;
	localparam logic ROW_ERASE_RST = 1'h0;
	localparam logic ABORT_RST     = 1'h0;
	localparam logic PERMIT_RST    = 1'h0;
	localparam logic WR_TRIG_RST   = 1'h0;
	localparam logic RD_TRIG_RST   = 1'h0;
	localparam logic [7:0] RDATA_RST = 8'h00;

	// read answer for an unmapped address
	localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

	typedef enum logic {
		PROG_IDLE,
		PROG_BUSY
	} prog_state_t;

endpackage

// File: design/nvm_prog_seq.sv
// sequencer for one self-timed program or erase cycle of the array
module nvm_prog_seq (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_b,
	// control from the register side
	input  wire logic start,
	input  wire logic erase_in,
	input  wire logic warm_reset,
	// array handshake
	input  wire logic prog_done,
	output logic      prog_req,
	output logic      prog_erase,
	output logic      prog_abort,
	output logic      busy
);

	nvm_ctrl_pkg::prog_state_t state_reg;
	nvm_ctrl_pkg::prog_state_t state_next;
	logic                      req_next;
	logic                      erase_next;
	logic                      abort_next;
	logic                      busy_next;

	always_comb begin
		state_next = state_reg;
		req_next   = 1'b0;
		erase_next = prog_erase;
		abort_next = 1'b0;
		unique case (state_reg)
			nvm_ctrl_pkg::PROG_IDLE: begin
				if (start && !warm_reset) begin
					state_next = nvm_ctrl_pkg::PROG_BUSY;
					req_next   = 1'b1;
					erase_next = erase_in;
				end
			end
			nvm_ctrl_pkg::PROG_BUSY: begin
				// a reset in flight kills the cycle; the array is told at once
				if (warm_reset) begin
					state_next = nvm_ctrl_pkg::PROG_IDLE;
					abort_next = 1'b1;
				end else if (prog_done) begin
					state_next = nvm_ctrl_pkg::PROG_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg  <= nvm_ctrl_pkg::PROG_IDLE;
			prog_req   <= 1'b0;
			prog_erase <= 1'b0;
			prog_abort <= 1'b0;
			busy       <= 1'b0;
		end else begin
			state_reg  <= state_next;
			prog_req   <= req_next;
			prog_erase <= erase_next;
			prog_abort <= abort_next;
			busy       <= busy_next;
		end
	end

	// busy is its own flop so the top output carries no decode behind it
	assign busy_next = (state_next == nvm_ctrl_pkg::PROG_BUSY);

endmodule // nvm_prog_seq

// File: verification/nvm_array_model.sv
// behavioural array that answers each program start after a set delay, unless an abort comes first
module nvm_array_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// handshake
	input  wire logic       prog_req,
	input  wire logic       prog_abort,
	input  wire logic [7:0] dly,
	output logic            prog_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_reg;
	// a killed cycle must never report completion later on
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			cnt_reg <= 8'h00;
		else if (prog_req)
			cnt_reg <= dly;
		else if (prog_abort)
			cnt_reg <= 8'h00;
		else if (cnt_reg != 8'h00)
			cnt_reg <= cnt_reg - 8'h01;
	end
	assign prog_done = (cnt_reg == 8'h01);
endmodule // nvm_array_model

// File: verification/tb.sv
// self-checking bench for the nonvolatile access control block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] OFS = nvm_ctrl_pkg::NVM_CONTROL_OFS;
	logic        mclk         = 1'b0;
	logic        rst_b        = 1'b0;
	logic        pin_rst_b    = 1'b1;
	logic        watchdog_rst = 1'b0;
	logic [11:0] reg_addr     = 12'h000;
	logic [7:0]  reg_wdata    = 8'h00;
	logic        reg_wr       = 1'b0;
	logic        reg_rd       = 1'b0;
	logic        rd_d         = 1'b0;
	logic [7:0]  dly          = 8'h28;
	logic [7:0]  reg_rdata;
	logic        done, f_sel, c_sel, r_req, p_req, p_erase, p_abort, p_busy;
	logic [7:0]  exp_q[$];
	integer      seed;
	int          num_errors   = 0;
	int          compares     = 0;
	wire  [7:0]  flags = {1'b0, f_sel, c_sel, r_req, p_req, p_erase, p_abort, p_busy};
	always #20 mclk = ~mclk;
	nvm_access_control dut (.mclk(mclk), .rst_b(rst_b), .external_reset_pin_b(pin_rst_b),
		.watchdog_timer_reset(watchdog_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nvm_prog_done(done),
		.nvm_flash_sel(f_sel), .nvm_cfg_sel(c_sel), .nvm_read_req(r_req),
		.nvm_prog_req(p_req), .nvm_prog_erase(p_erase), .nvm_prog_abort(p_abort),
		.nvm_prog_busy(p_busy));
	nvm_array_model model (.mclk(mclk), .rst_b(rst_b), .prog_req(p_req),
		.prog_abort(p_abort), .dly(dly), .prog_done(done));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// the expected answer is noted as the read is issued
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask
	task automatic idle_wait();
		int n;
		n = 0;
		while (p_busy !== 1'b0 && n < 300) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("busy", 8'h00, {7'h00, p_busy});
	endtask
	task automatic test_done();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge mclk) rd_d <= reg_rd;
	always @(negedge mclk) if (rd_d) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
	initial begin
		#400000;
		num_errors++;
		test_done();
	end
	initial begin
		int n;
		seed = 47762;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		rd(OFS, 8'h00);
		rd(12'hFA7, 8'h00);
		wr({4'h0, 8'($random(seed))}, 8'($random(seed)));
		wr(OFS, 8'h02);
		chk("flags", 8'h00, flags);
		rd(OFS, 8'h00);
		$display("test refusals done");
		wr(OFS, 8'h04);
		wr(OFS, 8'h06);
		chk("flags", 8'h09, flags);
		wr(OFS, 8'h04);
		rd(OFS, 8'h06);
		idle_wait();
		rd(OFS, 8'h04);
		$display("test write done");
		dly <= {3'h0, 5'($random(seed))} + 8'h02;
		wr(OFS, 8'h94);
		wr(OFS, 8'h96);
		chk("flags", 8'h4D, flags);
		idle_wait();
		rd(OFS, 8'h84);
		$display("test erase done");
		wr(OFS, 8'h85);
		chk("read_req", 8'h00, {7'h00, r_req});
		rd(OFS, 8'h84);
		wr(OFS, 8'h01);
		chk("read_req", 8'h01, {7'h00, r_req});
		chk("flash_sel", 8'h00, {7'h00, f_sel});
		rd(OFS, 8'h00);
		wr(OFS, 8'h60);
		chk("cfg_sel", 8'h01, {7'h00, c_sel});
		rd(OFS, 8'h40);
		$display("test read and select done");
		// slow array so that the warm reset lands mid-cycle
		dly <= 8'hC8;
		for (int s = 0; s < 2; s++) begin
			wr(OFS, 8'h94);
			wr(OFS, 8'h96);
			@(posedge mclk);
			watchdog_rst <= (s == 0);
			pin_rst_b <= (s == 0);
			@(posedge mclk);
			watchdog_rst <= 1'b0;
			pin_rst_b <= 1'b1;
			#1;
			n = 0;
			while (p_abort !== 1'b1 && n < 4) begin
				@(posedge mclk);
				#1;
				n++;
			end
			chk("abort", 8'h01, {7'h00, p_abort});
			idle_wait();
			rd(OFS, 8'h98);
		end
		$display("test abort done");
		// a second power-on reset after activity must clear every control bit again
		@(posedge mclk);
		rst_b <= 1'b0;
		@(posedge mclk);
		rst_b <= 1'b1;
		rd(OFS, 8'h00);
		$display("test reset done");
		@(posedge mclk);
		@(posedge mclk);
		test_done();
	end
endmodule // tb
